// File: core/term_pkg.sv
// Constants for the termination / standby command interpreter.
// Assumes a six-byte command block delivered one byte per clock.
package term_pkg;
	// Command block layout
	localparam logic [2:0] CDB_LEN    = 3'h6;
	localparam logic [2:0] IDX_OPC    = 3'h0;
	localparam logic [2:0] IDX_MODE   = 3'h3;
	localparam logic [2:0] IDX_CHAR   = 3'h4;
	localparam logic [7:0] OP_EOS     = 8'hc5;
	localparam logic [7:0] OP_EOT     = 8'hc6;
	localparam logic [7:0] OP_GTS     = 8'hc7;
	// Terminator mode bits
	localparam logic [7:0] MODE_RD    = 8'h04;
	localparam logic [7:0] MODE_WR    = 8'h08;
	localparam logic [7:0] MODE_FULL  = 8'h10;
	localparam logic [7:0] MODE_OFF   = 8'h00;
	localparam logic [7:0] MODE_DEF   = MODE_RD | MODE_WR | MODE_FULL;
	localparam logic [7:0] MASK_LOW7  = 8'h7f;
	localparam logic [7:0] MASK_ALL8  = 8'hff;
	localparam int         MODE_BIT   = 0;
	localparam logic       END_LAST_RST = 1'b1;
	// Status, message and sense codes
	localparam logic [7:0] STAT_GOOD  = 8'h00;
	localparam logic [7:0] STAT_CHECK = 8'h02;
	localparam logic [7:0] MSG_DONE   = 8'h00;
	localparam logic [3:0] SENSE_NONE    = 4'h0;
	localparam logic [3:0] SENSE_ILLEGAL = 4'h5;
	localparam logic [3:0] SENSE_ERROR   = 4'h9;
	// Register port map
	localparam logic [1:0] REG_STATUS = 2'h0;
	localparam logic [1:0] REG_EOS    = 2'h1;
	localparam logic [1:0] REG_CTRL   = 2'h2;
	localparam int         CTRL_ONLINE = 0;
	localparam int         CTRL_TAKE   = 1;
	localparam int         ST_END_LAST = 0;
	localparam int         ST_CIC      = 1;
	localparam int         ST_ACTIVE   = 5;
	localparam int         ST_SHADOW   = 6;
	localparam int         ST_HOLD     = 7;
	localparam int         ST_NOTCIC   = 8;
	localparam int         ST_TAKE_PND = 9;
	localparam int         REG_W       = 16;

	typedef enum logic [1:0] {PH_FREE, PH_COMMAND, PH_STATUS, PH_MSG_IN} phase_t;
endpackage : term_pkg

// File: core/bit_sync.sv
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,  // Device clock
	input  wire logic         rstn_i, // Synchronous reset, active low
	input  wire logic [W-1:0] d_i,    // Asynchronous levels
	output logic      [W-1:0] q_o     // Synchronised levels
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule : bit_sync
`default_nettype wire

// File: core/ieee488_termination_standby.sv
// Command interpreter for terminator, END-on-write and standby commands,
// plus the terminator match on read/write byte streams and shadow acceptor.
// Assumes a SCSI phase engine outside feeds command bytes and acks phases,
// and that the data engine outside streams bytes through the match ports.
//
// Functional notes
// - Mode bit 0x04: stop a bus read when a received byte matches terminator.
// - Mode bit 0x08: assert END with any written byte matching terminator.
// - Mode bit 0x10: compare all eight bits, else only the low seven.
// - Mode byte 0x00 disables read stop and write END insertion.
// - Read stop without 0x10 compares low seven bits only.
// - Write END without 0x10 compares low seven bits only.
// - Terminator byte is never inserted; host supplies it in write data.
// - All terminator modes are off after power-on.
// - Terminator settings persist until reissued, online, or power off.
// - Mode with only 0x10 is refused: check condition, illegal request.
// - Terminator command: opcode 0xC5, mode in byte 3, character in byte 4.
// - These commands run command, status, message-in phases; no data phase.
// - Opcode 0xC6 mode bit 1 sends END on last written byte, 0 suppresses.
// - END-on-last-byte defaults to enabled at power-on.
// - END-on-last-byte persists until reissued, online, or power off.
// - END is signalled by asserting EOI during the final byte.
// - Standby command opcode 0xC7; byte 3 bit 0 enables shadow handshake.
// - Active controller going to standby releases ATN.
// - Shadow acceptor handshakes without keeping data, holds off at END.
// - After hold-off, control can be taken synchronously without corruption.
// - Standby while not in charge: not-controller error, check, sense ERROR.
`timescale 1ns/1ps
`default_nettype none
module ieee488_termination_standby
	import term_pkg::*;
(
	input  wire logic              clk_i,        // Device clock, 250 MHz
	input  wire logic              rstn_i,       // Synchronous reset, active low
	// Command block from the SCSI phase engine
	input  wire logic              sel_i,        // Selected, start of command
	input  wire logic              cdb_valid_i,  // Command byte strobe
	input  wire logic [7:0]        cdb_byte_i,   // Command byte
	input  wire logic              phase_ack_i,  // Status or message byte taken
	output phase_t                 phase_o,      // Requested bus phase
	output logic      [7:0]        info_byte_o,  // Status or message byte
	output logic      [3:0]        sense_key_o,  // Sense key of last command
	output logic                   busy_o,       // Command in progress
	// Controller role
	input  wire logic              cic_i,        // Device is controller in charge
	// Read byte stream match
	input  wire logic              rd_valid_i,   // Received byte strobe
	input  wire logic [7:0]        rd_byte_i,    // Received byte
	output logic                   rd_stop_o,    // End the read at this byte
	// Write byte stream
	input  wire logic              wr_valid_i,   // Byte to send strobe
	input  wire logic [7:0]        wr_byte_i,    // Byte to send
	input  wire logic              wr_last_i,    // Last byte of the write
	output logic                   wr_valid_o,   // Byte to send, delayed
	output logic      [7:0]        wr_byte_o,    // Byte to send, unchanged
	output logic                   wr_eoi_o,     // Assert EOI with this byte
	// Bus pins, low-true lines
	input  wire logic              dav_n_i,      // Data valid
	input  wire logic              eoi_n_i,      // End or identify
	input  wire logic [7:0]        dio_n_i,      // Data lines
	output logic                   atn_n_o,      // Attention drive level
	output logic                   atn_oe_o,     // Attention driven
	output logic                   nrfd_n_o,     // Not ready drive level
	output logic                   nrfd_oe_o,    // Not ready driven
	output logic                   ndac_n_o,     // Not accepted drive level
	output logic                   ndac_oe_o,    // Not accepted driven
	// Register port
	input  wire logic [1:0]        reg_addr_i,   // Register address
	input  wire logic [REG_W-1:0]  reg_wdata_i,  // Write data
	input  wire logic              reg_wr_i,     // Write strobe
	input  wire logic              reg_rd_i,     // Read strobe
	output logic      [REG_W-1:0]  reg_rdata_o   // Read data, one cycle later
);
	typedef enum {C_IDLE, C_CMD, C_EXEC, C_STATUS, C_MSG} cmd_st_t;
	typedef enum {SH_OFF, SH_READY, SH_ACCEPT, SH_HOLD} sh_st_t;

	// Terminator match on the selected width
	function automatic logic term_match(input logic [7:0] b, input logic [7:0] c,
	                                    input logic [7:0] mode);
		logic [7:0] m;
		m = (mode & MODE_FULL) != MODE_OFF ? MASK_ALL8 : MASK_LOW7;
		return ((b ^ c) & m) == MODE_OFF;
	endfunction : term_match

	cmd_st_t    cst_q;
	sh_st_t     sst_q;
	logic [2:0] cnt_q;
	logic [7:0] opc_q;
	logic [7:0] mode_q;
	logic [7:0] chr_q;
	logic [7:0] eos_mode_q;
	logic [7:0] eos_char_q;
	logic       end_last_q;
	logic       active_q;
	logic       shadow_q;
	logic       notcic_q;
	logic       take_q;
	logic       end_seen_q;
	logic [1:0] bus_s;
	logic [7:0] dio_s;

	bit_sync #(.W(2)) u_ctl_sync (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.d_i    ({~dav_n_i, ~eoi_n_i}),
		.q_o    (bus_s)
	);
	bit_sync #(.W(8)) u_dio_sync (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.d_i    (~dio_n_i),
		.q_o    (dio_s)
	);

	wire dav_s = bus_s[1];
	wire eoi_s = bus_s[0];

	// Command decode
	wire [7:0] mode_def  = mode_q & MODE_DEF;
	wire       is_eos    = opc_q == OP_EOS;
	wire       is_eot    = opc_q == OP_EOT;
	wire       is_gts    = opc_q == OP_GTS;
	wire       eos_bad   = is_eos && mode_def == MODE_FULL;
	wire       gts_bad   = is_gts && !cic_i;
	wire       op_bad    = !(is_eos || is_eot || is_gts);
	wire       cmd_fail  = eos_bad || gts_bad || op_bad;
	wire [3:0] sense_d   = gts_bad ? SENSE_ERROR :
	                       (eos_bad || op_bad) ? SENSE_ILLEGAL : SENSE_NONE;
	wire       exec      = cst_q == C_EXEC;
	wire       online    = reg_wr_i && reg_addr_i == REG_CTRL && reg_wdata_i[CTRL_ONLINE];
	wire       take_req  = reg_wr_i && reg_addr_i == REG_CTRL && reg_wdata_i[CTRL_TAKE];
	wire       standby   = cic_i && !active_q;
	wire       sh_quiet  = sst_q != SH_ACCEPT;
	wire       take_now  = (take_q || take_req) && cic_i && !active_q && sh_quiet;

	// Byte-stream matches
	wire       rd_hit    = (eos_mode_q & MODE_RD) != MODE_OFF &&
	                       term_match(rd_byte_i, eos_char_q, eos_mode_q);
	wire       wr_hit    = (eos_mode_q & MODE_WR) != MODE_OFF &&
	                       term_match(wr_byte_i, eos_char_q, eos_mode_q);
	wire       sh_hit    = (eos_mode_q & MODE_RD) != MODE_OFF &&
	                       term_match(dio_s, eos_char_q, eos_mode_q);

	// Command sequencer: command, status, message in; no data phase
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cst_q <= C_IDLE;
			cnt_q <= '0;
		end else begin
			unique case (cst_q)
				C_IDLE: begin
					cnt_q <= '0;
					if (sel_i) begin
						cst_q <= C_CMD;
					end
				end
				C_CMD: begin
					if (cdb_valid_i) begin
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == CDB_LEN - 3'h1) begin
							cst_q <= C_EXEC;
						end
					end
				end
				C_EXEC: begin
					cst_q <= C_STATUS;
				end
				C_STATUS: begin
					if (phase_ack_i) begin
						cst_q <= C_MSG;
					end
				end
				C_MSG: begin
					if (phase_ack_i) begin
						cst_q <= C_IDLE;
					end
				end
			endcase
		end
	end

	// Capture only opcode, mode and character bytes
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			opc_q  <= '0;
			mode_q <= '0;
			chr_q  <= '0;
		end else if (cst_q == C_CMD && cdb_valid_i) begin
			if (cnt_q == IDX_OPC) begin
				opc_q <= cdb_byte_i;
			end
			if (cnt_q == IDX_MODE) begin
				mode_q <= cdb_byte_i;
			end
			if (cnt_q == IDX_CHAR) begin
				chr_q <= cdb_byte_i;
			end
		end
	end

	// Phase outputs
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			phase_o     <= PH_FREE;
			info_byte_o <= STAT_GOOD;
			sense_key_o <= SENSE_NONE;
			busy_o      <= 1'b0;
		end else begin
			busy_o <= cst_q != C_IDLE || sel_i;
			if (exec) begin
				phase_o     <= PH_STATUS;
				info_byte_o <= cmd_fail ? STAT_CHECK : STAT_GOOD;
				sense_key_o <= sense_d;
			end else if (cst_q == C_STATUS && phase_ack_i) begin
				phase_o     <= PH_MSG_IN;
				info_byte_o <= MSG_DONE;
			end else if (cst_q == C_MSG && phase_ack_i) begin
				phase_o <= PH_FREE;
			end else if (cst_q == C_IDLE && sel_i) begin
				phase_o <= PH_COMMAND;
			end
		end
	end

	// Terminator and END-on-last settings
	always_ff @(posedge clk_i) begin
		if (!rstn_i || online) begin
			eos_mode_q <= MODE_OFF;
			eos_char_q <= '0;
			end_last_q <= END_LAST_RST;
		end else if (exec && is_eos && !eos_bad) begin
			eos_mode_q <= mode_def;
			eos_char_q <= chr_q;
		end else if (exec && is_eot) begin
			end_last_q <= mode_q[MODE_BIT];
		end
	end

	// Controller role and not-controller error flag
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			active_q <= 1'b1;
			shadow_q <= 1'b0;
			notcic_q <= 1'b0;
			take_q   <= 1'b0;
		end else begin
			if (!cic_i) begin
				active_q <= 1'b1;
			end else if (exec && is_gts) begin
				active_q <= 1'b0;
			end else if (take_now) begin
				active_q <= 1'b1;
			end
			if (exec && is_gts && cic_i) begin
				shadow_q <= mode_q[MODE_BIT];
			end
			if (exec && gts_bad) begin
				notcic_q <= 1'b1;
			end else if (exec) begin
				notcic_q <= 1'b0;
			end
			if (take_now || !cic_i) begin
				take_q <= 1'b0;
			end else if (take_req) begin
				take_q <= 1'b1;
			end
		end
	end

	// Shadow acceptor: handshakes without storing data, holds off at END
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sst_q      <= SH_OFF;
			end_seen_q <= 1'b0;
		end else if (!standby || !shadow_q || take_now) begin
			sst_q      <= SH_OFF;
			end_seen_q <= 1'b0;
		end else begin
			unique case (sst_q)
				SH_OFF: begin
					sst_q <= SH_READY;
				end
				SH_READY: begin
					if (dav_s) begin
						sst_q      <= SH_ACCEPT;
						end_seen_q <= eoi_s || sh_hit;
					end
				end
				SH_ACCEPT: begin
					if (!dav_s) begin
						sst_q <= end_seen_q ? SH_HOLD : SH_READY;
					end
				end
				SH_HOLD: begin
					sst_q <= SH_HOLD;
				end
			endcase
		end
	end

	// Bus line drives; oe high while pulling the line low
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			atn_n_o   <= 1'b0;
			atn_oe_o  <= 1'b0;
			nrfd_n_o  <= 1'b0;
			nrfd_oe_o <= 1'b0;
			ndac_n_o  <= 1'b0;
			ndac_oe_o <= 1'b0;
		end else begin
			atn_n_o   <= 1'b0;
			ndac_n_o  <= 1'b0;
			nrfd_n_o  <= 1'b0;
			atn_oe_o  <= cic_i && (active_q || take_now);
			nrfd_oe_o <= sst_q == SH_ACCEPT || sst_q == SH_HOLD;
			ndac_oe_o <= sst_q == SH_READY || sst_q == SH_HOLD;
		end
	end

	// Read stop and write END flags, data passed unchanged
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rd_stop_o  <= 1'b0;
			wr_valid_o <= 1'b0;
			wr_byte_o  <= '0;
			wr_eoi_o   <= 1'b0;
		end else begin
			rd_stop_o  <= rd_valid_i && rd_hit;
			wr_valid_o <= wr_valid_i;
			wr_byte_o  <= wr_byte_i;
			wr_eoi_o   <= wr_valid_i && (wr_hit || (end_last_q && wr_last_i));
		end
	end

	// Register read, data valid only in the cycle after the strobe
	wire [REG_W-1:0] status_w = REG_W'(eos_mode_q & MODE_DEF)
	                          | (REG_W'(end_last_q) << ST_END_LAST)
	                          | (REG_W'(cic_i) << ST_CIC)
	                          | (REG_W'(active_q) << ST_ACTIVE)
	                          | (REG_W'(shadow_q) << ST_SHADOW)
	                          | (REG_W'(sst_q == SH_HOLD) << ST_HOLD)
	                          | (REG_W'(notcic_q) << ST_NOTCIC)
	                          | (REG_W'(take_q) << ST_TAKE_PND);
	wire [REG_W-1:0] rd_mux   = reg_addr_i == REG_STATUS ? status_w :
	                            reg_addr_i == REG_EOS ? REG_W'(eos_char_q) : '0;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_mux : '0;
		end
	end
endmodule : ieee488_termination_standby
`default_nettype wire

// File: tb/term_monitor.sv
// Checker on the interpreter's ports.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module term_monitor
	import term_pkg::*;
(
	input wire logic             clk_i,       // Clock
	input wire logic             rstn_i,      // Reset, active low
	input wire logic             sel_i,       // Start
	input wire logic             phase_ack_i, // Byte taken
	input wire phase_t           phase_o,     // Phase
	input wire logic [7:0]       info_byte_o, // Status or message
	input wire logic             busy_o,      // Busy
	input wire logic             cic_i,       // In charge
	input wire logic             rd_valid_i,  // Read strobe
	input wire logic             rd_stop_o,   // Read stop
	input wire logic             wr_valid_i,  // Write strobe
	input wire logic [7:0]       wr_byte_i,   // Byte in
	input wire logic             wr_valid_o,  // Strobe out
	input wire logic [7:0]       wr_byte_o,   // Byte out
	input wire logic             wr_eoi_o,    // EOI
	input wire logic             atn_oe_o     // Attention driven
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	a_sel_busy: assert property (sel_i && !busy_o |=> busy_o) else $error("busy not raised");
	a_no_data_ph: assert property (phase_o == PH_COMMAND |=> phase_o inside {PH_COMMAND, PH_STATUS})
		else $error("bad phase after command");
	a_status_stands: assert property (phase_o == PH_STATUS && !phase_ack_i |=>
		phase_o == PH_STATUS && $stable(info_byte_o)) else $error("status dropped");
	a_msg_follows: assert property (phase_o == PH_STATUS && phase_ack_i |=>
		phase_o == PH_MSG_IN && info_byte_o == MSG_DONE) else $error("no message phase");
	a_wr_pass: assert property (wr_valid_i |=> wr_valid_o && wr_byte_o == $past(wr_byte_i))
		else $error("write byte altered");
	a_wr_no_insert: assert property (!wr_valid_i |=> !wr_valid_o) else $error("byte inserted");
	a_eoi_on_byte: assert property (wr_eoi_o |-> wr_valid_o) else $error("eoi without byte");
	a_stop_cause: assert property (rd_stop_o |-> $past(rd_valid_i)) else $error("stop without byte");
	a_atn_not_cic: assert property (!cic_i |=> !atn_oe_o) else $error("atn while not in charge");
endmodule : term_monitor
`default_nettype wire

// File: tb/talker_model.sv
// Talker on the instrument bus for standby tests.
// Assumes the device is the only listener; released lines float high.
`timescale 1ns/1ps
`default_nettype none
module talker_model (
	input wire logic  clk_i,   // Clock
	input wire logic  nrfd_i,  // Ready line level
	input wire logic  ndac_i,  // Accepted line level
	output logic      dav_n_o, // Data valid
	output logic      eoi_n_o, // End
	output logic [7:0] dio_n_o // Data lines
);
	initial begin
		dav_n_o = 1'b1;
		eoi_n_o = 1'b1;
		dio_n_o = 8'hff;
	end
	task automatic send(input logic [7:0] b, input logic e, output logic ok);
		int n;
		int w;
		for (w = 0; w < 100 && nrfd_i !== 1'b1; w++) @(posedge clk_i);
		@(posedge clk_i);
		dio_n_o <= ~b;
		eoi_n_o <= ~e;
		@(posedge clk_i);
		dav_n_o <= 1'b0;
		for (n = 0; n < 200 && ndac_i !== 1'b1; n++) @(posedge clk_i);
		@(posedge clk_i);
		dav_n_o <= 1'b1;
		eoi_n_o <= 1'b1;
		dio_n_o <= 8'hff;
		ok = (w < 100) && (n < 200);
	endtask : send
endmodule : talker_model
`default_nettype wire

// File: tb/ieee488_termination_standby_bench.sv
// Bench for the terminator, END-on-write and standby interpreter.
// Drives command, stream and register ports; a talker model holds the bus pins.
`timescale 1ns/1ps
`default_nettype none
module ieee488_termination_standby_bench;
	import term_pkg::*;
	logic clk_i = 1'b0, rstn_i = 1'b0, sel_i = 1'b0, cdb_valid_i = 1'b0, phase_ack_i = 1'b0, cic_i = 1'b1;
	logic rd_valid_i = 1'b0, wr_valid_i = 1'b0, wr_last_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [7:0] cdb_byte_i = 8'h00, rd_byte_i = 8'h00, wr_byte_i = 8'h00, info_byte_o, wr_byte_o, dio_n_i;
	logic [1:0] reg_addr_i = 2'h0;
	logic [REG_W-1:0] reg_wdata_i = 16'h0000, reg_rdata_o, s;
	logic busy_o, rd_stop_o, wr_valid_o, wr_eoi_o, dav_n_i, eoi_n_i, atn_n_o, atn_oe_o, nrfd_n_o, nrfd_oe_o;
	logic ndac_n_o, ndac_oe_o, ok;
	logic [3:0] sense_key_o;
	phase_t phase_o;
	int miscompares = 0, samples_checked = 0;

	always #2 clk_i = ~clk_i;

	ieee488_termination_standby u_ieee488_termination_standby (.clk_i, .rstn_i, .sel_i, .cdb_valid_i,
		.cdb_byte_i, .phase_ack_i, .phase_o, .info_byte_o, .sense_key_o, .busy_o, .cic_i, .rd_valid_i,
		.rd_byte_i, .rd_stop_o, .wr_valid_i, .wr_byte_i, .wr_last_i, .wr_valid_o, .wr_byte_o, .wr_eoi_o,
		.dav_n_i, .eoi_n_i, .dio_n_i, .atn_n_o, .atn_oe_o, .nrfd_n_o, .nrfd_oe_o, .ndac_n_o, .ndac_oe_o,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
	talker_model u_talker_model (.clk_i, .nrfd_i(nrfd_oe_o ? nrfd_n_o : 1'b1),
		.ndac_i(ndac_oe_o ? ndac_n_o : 1'b1), .dav_n_o(dav_n_i), .eoi_n_o(eoi_n_i), .dio_n_o(dio_n_i));

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic bound(input int n);
		if (n >= 200) begin
			miscompares++;
			$display("[ERR] wait expected done seen timeout");
			close_out();
		end
	endtask : bound
	task automatic rd_reg(input logic [1:0] a);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		s = reg_rdata_o;
	endtask : rd_reg
	task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		repeat (2) @(negedge clk_i);
	endtask : wr_reg
	// Status register bits under a mask
	task automatic st(input logic [15:0] m, input logic [15:0] e);
		rd_reg(REG_STATUS);
		chk("status reg", s & m, e);
	endtask : st
	task automatic ack();
		@(posedge clk_i);
		phase_ack_i <= 1'b1;
		@(posedge clk_i);
		phase_ack_i <= 1'b0;
		@(negedge clk_i);
	endtask : ack
	// Whole command: select, six bytes (reserved ones nonzero), status, message
	task automatic cmd(input logic [7:0] op, md, ch, st_e, input logic [3:0] sk);
		int n;
		@(posedge clk_i);
		sel_i <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			sel_i <= 1'b0;
			cdb_valid_i <= 1'b1;
			cdb_byte_i <= (i == 0) ? op : (i == 3) ? md : (i == 4) ? ch : 8'ha5;
		end
		@(posedge clk_i);
		cdb_valid_i <= 1'b0;
		@(negedge clk_i);
		for (n = 0; n < 200 && phase_o !== PH_STATUS; n++) @(negedge clk_i);
		bound(n);
		chk("status byte", info_byte_o, st_e);
		chk("sense", sense_key_o, sk);
		ack();
		chk("msg phase", phase_o, PH_MSG_IN);
		ack();
		for (n = 0; n < 200 && busy_o !== 1'b0; n++) @(negedge clk_i);
		bound(n);
	endtask : cmd
	task automatic strm(input logic rd, input logic [7:0] b, input logic last, input logic exp);
		@(posedge clk_i);
		rd_valid_i <= rd;
		wr_valid_i <= !rd;
		rd_byte_i <= b;
		wr_byte_i <= b;
		wr_last_i <= last;
		@(posedge clk_i);
		rd_valid_i <= 1'b0;
		wr_valid_i <= 1'b0;
		@(negedge clk_i);
		if (rd) chk("rd stop", {wr_valid_o, rd_stop_o}, {1'b0, exp});
		else chk("wr eoi", {wr_valid_o, wr_eoi_o, wr_byte_o}, {1'b1, exp, b});
	endtask : strm
	// Shadow standby, one plain byte, then one byte ending the stream, then take control
	task automatic shadow_end(input logic [7:0] b, input logic e);
		cmd(OP_GTS, 8'h01, 8'h00, STAT_GOOD, SENSE_NONE);
		chk("ready", {nrfd_oe_o, ndac_oe_o}, 2'b01);
		u_talker_model.send(8'h41, 1'b0, ok);
		repeat (8) @(negedge clk_i);
		chk("no hold", {ok, nrfd_oe_o, ndac_oe_o}, 3'b101);
		u_talker_model.send(b, e, ok);
		repeat (8) @(negedge clk_i);
		chk("hold", {ok, nrfd_oe_o, ndac_oe_o}, 3'b111);
		st(16'h00e0, 16'h00c0);
		wr_reg(REG_CTRL, 16'h0002);
		chk("take atn", atn_oe_o, 1'b1);
		st(16'h00a0, 16'h0020);
	endtask : shadow_end

	initial begin
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (2) @(negedge clk_i);
		chk("reset atn", atn_oe_o, 1'b1);
		st(16'h03ff, 16'h0023);
		cmd(8'hc8, 8'h04, 8'h0a, STAT_CHECK, SENSE_ILLEGAL);
		st(16'h001c, 16'h0000);
		cmd(OP_EOS, 8'he4, 8'h0a, STAT_GOOD, SENSE_NONE);
		rd_reg(REG_EOS);
		chk("term char", s, 16'h000a);
		strm(1'b1, 8'h8a, 1'b0, 1'b1);
		strm(1'b1, 8'h0b, 1'b0, 1'b0);
		strm(1'b0, 8'h0a, 1'b0, 1'b0);
		cmd(OP_EOS, 8'h14, 8'h0a, STAT_GOOD, SENSE_NONE);
		strm(1'b1, 8'h8a, 1'b0, 1'b0);
		strm(1'b1, 8'h0a, 1'b0, 1'b1);
		cmd(OP_EOS, 8'h08, 8'h0d, STAT_GOOD, SENSE_NONE);
		strm(1'b0, 8'h8d, 1'b0, 1'b1);
		strm(1'b1, 8'h0d, 1'b0, 1'b0);
		cmd(OP_EOS, 8'h18, 8'h0d, STAT_GOOD, SENSE_NONE);
		strm(1'b0, 8'h8d, 1'b0, 1'b0);
		cmd(OP_EOS, 8'h10, 8'h33, STAT_CHECK, SENSE_ILLEGAL);
		st(16'h001c, 16'h0018);
		strm(1'b0, 8'h0d, 1'b0, 1'b1);
		cmd(OP_EOT, 8'hfe, 8'h00, STAT_GOOD, SENSE_NONE);
		strm(1'b0, 8'h41, 1'b1, 1'b0);
		cmd(OP_EOS, 8'h00, 8'h0d, STAT_GOOD, SENSE_NONE);
		strm(1'b0, 8'h0d, 1'b1, 1'b0);
		strm(1'b1, 8'h0d, 1'b0, 1'b0);
		cmd(OP_EOT, 8'h01, 8'h00, STAT_GOOD, SENSE_NONE);
		strm(1'b0, 8'h41, 1'b1, 1'b1);
		strm(1'b0, 8'h42, 1'b0, 1'b0);
		cmd(OP_EOS, 8'h04, 8'h0a, STAT_GOOD, SENSE_NONE);
		cmd(OP_EOT, 8'h00, 8'h00, STAT_GOOD, SENSE_NONE);
		wr_reg(REG_CTRL, 16'h0001);
		st(16'h001d, 16'h0001);
		@(posedge clk_i);
		cic_i <= 1'b0;
		cmd(OP_GTS, 8'h01, 8'h00, STAT_CHECK, SENSE_ERROR);
		st(16'h0100, 16'h0100);
		@(posedge clk_i);
		cic_i <= 1'b1;
		cmd(OP_GTS, 8'hfe, 8'h00, STAT_GOOD, SENSE_NONE);
		chk("standby atn", atn_oe_o, 1'b0);
		st(16'h01e0, 16'h0000);
		u_talker_model.send(8'h41, 1'b1, ok);
		chk("no shadow", {ok, nrfd_oe_o, ndac_oe_o}, 3'b100);
		wr_reg(REG_CTRL, 16'h0002);
		chk("take atn", atn_oe_o, 1'b1);
		cmd(OP_EOS, 8'h04, 8'h0a, STAT_GOOD, SENSE_NONE);
		shadow_end(8'h55, 1'b1);
		shadow_end(8'h8a, 1'b0);
		// Take requested while a byte is being accepted is deferred to its end
		cmd(OP_GTS, 8'h01, 8'h00, STAT_GOOD, SENSE_NONE);
		fork
			u_talker_model.send(8'h41, 1'b0, ok);
			begin
				repeat (5) @(negedge clk_i);
				wr_reg(REG_CTRL, 16'h0002);
				chk("take deferred", atn_oe_o, 1'b0);
			end
		join
		repeat (8) @(negedge clk_i);
		chk("take after", {ok, atn_oe_o, nrfd_oe_o, ndac_oe_o}, 4'b1100);
		st(16'h0220, 16'h0020);
		// Reset in mid-run restores power-on settings
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (2) @(negedge clk_i);
		chk("rerun atn", atn_oe_o, 1'b1);
		st(16'h03ff, 16'h0023);
		close_out();
	end
endmodule : ieee488_termination_standby_bench
bind ieee488_termination_standby term_monitor u_term_monitor (.clk_i, .rstn_i, .sel_i, .phase_ack_i,
	.phase_o, .info_byte_o, .busy_o, .cic_i, .rd_valid_i, .rd_stop_o, .wr_valid_i, .wr_byte_i,
	.wr_valid_o, .wr_byte_o, .wr_eoi_o, .atn_oe_o);
`default_nettype wire
